// File: common/xod_map.svh
// constants for the extended opcode and address decoder
// Operation
// - signed/unsigned range check, 3 cycles
// - 16-bit check 3, unsigned 2 cycles
// - sign extend 16/byte to word, 3 cycles
// - load 16-bit sign extended, 1 cycle
// - load byte sign extended, 1 cycle
// - device loads and stores take 3 cycles
// - peripherals reached only by device operations
// - wait 5 to 11, signal 7 to 12
// - swap queue 4, insert queue 3 to 4
// - global interrupt disable/enable, 5 cycles
// - load shadow 6-31, store shadow 6-17
// - trap handler/status load/store, 12 cycles
// - trap enable/disable 4, return 8-10
// - clock operations take 2 cycles each
// - product identity and no-op, 1 cycle
// - 30-bit word address plus byte selector
// - top two address bits select bank
// - bits 20 to 29 not driven out
// - channel state words below user memory base
// - trap area: two priorities, four groups
// - mask ROM at top of bank 1
// - boot entry two bytes below top
// - device ops in peripheral range hit peripherals
// - SRAM from bottom, external RAM at 81000000
`ifndef XOD_MAP_SVH
`define XOD_MAP_SVH
`define XOD_OP_CIR 16'h2CF7
`define XOD_OP_CIRU 16'h2CFC
`define XOD_OP_CB 16'h2BFA
`define XOD_OP_CBU 16'h2BFB
`define XOD_OP_CS 16'h2FFA
`define XOD_OP_CSU 16'h2FFB
`define XOD_OP_XSW 16'h2FF8
`define XOD_OP_XBW 16'h2BF8
`define XOD_OP_SSUB 16'h2CF1
`define XOD_OP_LDS 16'h2CFA
`define XOD_OP_STS 16'h2CF8
`define XOD_OP_LBX 16'h2BF9
`define XOD_OP_LSX 16'h2FF9
`define XOD_OP_DLB 16'h2FF0
`define XOD_OP_DLS 16'h2FF2
`define XOD_OP_DLW 16'h2FF4
`define XOD_OP_DSB 16'h2FF1
`define XOD_OP_DSS 16'h2FF3
`define XOD_OP_DSW 16'h2FF5
`define XOD_OP_WAIT 16'h60F5
`define XOD_OP_SIGNAL 16'h60F4
`define XOD_OP_SWAPQ 16'h60F0
`define XOD_OP_SWAPT 16'h60F1
`define XOD_OP_INSQ 16'h60F2
`define XOD_OP_TSLICE 16'h60F3
`define XOD_OP_LDSHAD 16'h60FC
`define XOD_OP_STSHAD 16'h60FD
`define XOD_OP_RESTART 16'h62FE
`define XOD_OP_CAUSEERR 16'h62FF
`define XOD_OP_IRET 16'h61FF
`define XOD_OP_SETTS 16'h2BF0
`define XOD_OP_INTDIS 16'h2CF4
`define XOD_OP_INTENB 16'h2CF5
`define XOD_OP_GINTDIS 16'h2CFD
`define XOD_OP_GINTENB 16'h2CFE
`define XOD_OP_LDTRAPH 16'h26FE
`define XOD_OP_LDTRAPPED 16'h2CF6
`define XOD_OP_STTRAPPED 16'h2CFB
`define XOD_OP_STTRAPH 16'h26FF
`define XOD_OP_TRAPENB 16'h60F7
`define XOD_OP_TRAPDIS 16'h60F6
`define XOD_OP_TRET 16'h60FB
`define XOD_OP_PRODID 16'h68FC
`define XOD_OP_NOP 16'h63F0
`define XOD_OP_CLKENB 16'h64FF
`define XOD_OP_CLKDIS 16'h64FE
`define XOD_OP_LDCLK 16'h64FD
`define XOD_OP_STCLK 16'h64FC
// cycle budgets
`define XOD_CYC_1 5'h01
`define XOD_CYC_2 5'h02
`define XOD_CYC_3 5'h03
`define XOD_CYC_4 5'h04
`define XOD_CYC_5 5'h05
`define XOD_CYC_6 5'h06
`define XOD_CYC_7 5'h07
`define XOD_CYC_8 5'h08
`define XOD_CYC_9 5'h09
`define XOD_CYC_10 5'h0A
`define XOD_CYC_11 5'h0B
`define XOD_CYC_12 5'h0C
`define XOD_CYC_17 5'h11
`define XOD_CYC_20 5'h14
`define XOD_CYC_31 5'h1F
// address map
`define XOD_PERIPH_LO 32'h0000_0000
`define XOD_PERIPH_HI 32'h3FFF_FFFF
`define XOD_ROM_BASE 32'h7FFE_0000
`define XOD_ROM_TOP 32'h7FFF_FFFF
`define XOD_BOOT_ENTRY 32'h7FFF_FFFE
`define XOD_LOWEST_ADDR 32'h8000_0000
`define XOD_SRAM_TOP 32'h8000_FFFF
`define XOD_EXT_RAM_BASE 32'h8100_0000
`define XOD_CHAN_BASE 32'h8000_0010
`define XOD_CHAN_TOP 32'h8000_001F
`define XOD_TRAP_BASE 32'h8000_0040
`define XOD_USER_MEM_BASE 32'h8000_0140
`define XOD_TRAP_PRI_BIT 8
`define XOD_TRAP_GRP_HI 7
`define XOD_TRAP_GRP_LO 6
`define XOD_TRAP_STRUCT_BIT 4
`define XOD_EXT_ADDR_W 20
`define XOD_BANK_HI 31
`define XOD_BANK_LO 30
`endif

// File: common/xod_pkg.sv
// types for the extended opcode and address decoder
package xod_pkg;
   typedef enum logic [3:0] {
      XOD_TGT_NONE = 4'b0001,
      XOD_TGT_MEM = 4'b0010,
      XOD_TGT_PERIPH = 4'b0100,
      XOD_TGT_ROM = 4'b1000
   } xod_target_t;
   typedef enum logic [2:0] {
      XOD_IDLE = 3'b001,
      XOD_BUSY = 3'b010,
      XOD_WAITDONE = 3'b100
   } xod_state_t;
   typedef struct packed {
      logic legal;
      logic ranged;
      logic dev_op;
      logic mem_op;
      logic [4:0] min_cyc;
      logic [4:0] max_cyc;
   } xod_info_t;
endpackage : xod_pkg

// File: design/xod_addr_decode.sv
// address space decode: bank, target, reserved areas
`timescale 1ns/10ps
`default_nettype none
`include "xod_map.svh"
module xod_addr_decode
   import xod_pkg::*;
(
   input wire logic [31:0] addr_i,
   input wire logic dev_op_i,
   input wire logic rom_programmed_i,
   output logic [1:0] bank_o,
   output logic [29:0] word_addr_o,
   output logic [1:0] byte_sel_o,
   output logic [19:0] ext_addr_o,
   output xod_target_t target_o,
   output logic sram_o,
   output logic chan_area_o,
   output logic trap_area_o,
   output logic trap_pri_o,
   output logic [1:0] trap_grp_o,
   output logic trap_struct_o
);
   logic periph_range;
   logic rom_range;
   assign word_addr_o = addr_i[31:2];
   assign byte_sel_o = addr_i[1:0];
   assign bank_o = addr_i[`XOD_BANK_HI:`XOD_BANK_LO];
   // upper internal bits stay on chip
   assign ext_addr_o = addr_i[`XOD_EXT_ADDR_W-1:0];
   assign periph_range = (addr_i <= `XOD_PERIPH_HI);
   // signed space: rom sits just below the highest address
   assign rom_range = (addr_i >= `XOD_ROM_BASE) && (addr_i <= `XOD_ROM_TOP);
   assign sram_o = (addr_i >= `XOD_LOWEST_ADDR) && (addr_i <= `XOD_SRAM_TOP);
   assign chan_area_o = (addr_i >= `XOD_CHAN_BASE) && (addr_i <= `XOD_CHAN_TOP);
   assign trap_area_o = (addr_i >= `XOD_TRAP_BASE) && (addr_i < `XOD_USER_MEM_BASE);
   assign trap_pri_o = addr_i[`XOD_TRAP_PRI_BIT] ^ 1'b1;
   assign trap_grp_o = addr_i[`XOD_TRAP_GRP_HI:`XOD_TRAP_GRP_LO];
   assign trap_struct_o = addr_i[`XOD_TRAP_STRUCT_BIT];
   always_comb begin
      if (dev_op_i && periph_range) begin
         target_o = XOD_TGT_PERIPH;
      end else if (rom_range && rom_programmed_i) begin
         target_o = XOD_TGT_ROM;
      end else begin
         target_o = XOD_TGT_MEM;
      end
   end
endmodule : xod_addr_decode
`default_nettype wire

// File: design/xod_decoder.sv
// extended opcode decoder with cycle sequencing
`timescale 1ns/10ps
`default_nettype none
`include "xod_map.svh"
module xod_decoder
   import xod_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire logic instr_valid_i,
   input wire logic [15:0] opcode_i,
   input wire logic [31:0] addr_i,
   input wire logic exec_done_i,
   input wire logic boot_i,
   input wire logic rom_programmed_i,
   output logic instr_ready_o,
   output logic exec_start_o,
   output logic [15:0] exec_op_o,
   output logic [4:0] exec_cycles_o,
   output logic illegal_o,
   output logic busy_o,
   output logic periph_sel_o,
   output logic mem_sel_o,
   output logic rom_sel_o,
   output logic [1:0] bank_o,
   output logic [29:0] word_addr_o,
   output logic [1:0] byte_sel_o,
   output logic [19:0] ext_addr_o,
   output logic reserved_hit_o,
   output logic [31:0] boot_pc_o
);
   function automatic xod_info_t info(input logic [15:0] op);
      xod_info_t r;
      r = '{legal: 1'b1, ranged: 1'b0, dev_op: 1'b0, mem_op: 1'b0,
            min_cyc: `XOD_CYC_1, max_cyc: `XOD_CYC_1};
      case (op)
         `XOD_OP_CIR, `XOD_OP_CIRU: begin
            r.min_cyc = `XOD_CYC_3;
         end
         `XOD_OP_CB, `XOD_OP_CS: begin
            r.min_cyc = `XOD_CYC_3;
         end
         `XOD_OP_CBU, `XOD_OP_CSU: begin
            r.min_cyc = `XOD_CYC_2;
         end
         `XOD_OP_XSW, `XOD_OP_XBW: begin
            r.min_cyc = `XOD_CYC_3;
         end
         `XOD_OP_SSUB: begin
            r.min_cyc = `XOD_CYC_1;
         end
         `XOD_OP_LDS: begin
            r.mem_op = 1'b1;
         end
         `XOD_OP_STS: begin
            r.mem_op = 1'b1;
            r.min_cyc = `XOD_CYC_2;
         end
         `XOD_OP_LSX: begin
            r.mem_op = 1'b1;
         end
         `XOD_OP_LBX: begin
            r.mem_op = 1'b1;
         end
         `XOD_OP_DLB, `XOD_OP_DLS, `XOD_OP_DLW,
         `XOD_OP_DSB, `XOD_OP_DSS, `XOD_OP_DSW: begin
            r.dev_op = 1'b1;
            r.min_cyc = `XOD_CYC_3;
         end
         `XOD_OP_WAIT: begin
            r.ranged = 1'b1;
            r.min_cyc = `XOD_CYC_5;
            r.max_cyc = `XOD_CYC_11;
         end
         `XOD_OP_SIGNAL: begin
            r.ranged = 1'b1;
            r.min_cyc = `XOD_CYC_7;
            r.max_cyc = `XOD_CYC_12;
         end
         `XOD_OP_SWAPQ, `XOD_OP_TRAPENB, `XOD_OP_TRAPDIS: begin
            r.min_cyc = `XOD_CYC_4;
         end
         `XOD_OP_SWAPT, `XOD_OP_GINTDIS, `XOD_OP_GINTENB: begin
            r.min_cyc = `XOD_CYC_5;
         end
         `XOD_OP_INSQ, `XOD_OP_TSLICE: begin
            r.ranged = 1'b1;
            r.min_cyc = `XOD_CYC_3;
            r.max_cyc = `XOD_CYC_4;
         end
         `XOD_OP_LDSHAD: begin
            r.ranged = 1'b1;
            r.min_cyc = `XOD_CYC_6;
            r.max_cyc = `XOD_CYC_31;
         end
         `XOD_OP_STSHAD: begin
            r.ranged = 1'b1;
            r.min_cyc = `XOD_CYC_6;
            r.max_cyc = `XOD_CYC_17;
         end
         `XOD_OP_RESTART: begin
            r.min_cyc = `XOD_CYC_20;
         end
         `XOD_OP_CAUSEERR: begin
            r.ranged = 1'b1;
            r.min_cyc = `XOD_CYC_7;
            r.max_cyc = `XOD_CYC_8;
         end
         `XOD_OP_IRET: begin
            r.ranged = 1'b1;
            r.min_cyc = `XOD_CYC_3;
            r.max_cyc = `XOD_CYC_11;
         end
         `XOD_OP_SETTS, `XOD_OP_INTDIS, `XOD_OP_INTENB: begin
            r.min_cyc = `XOD_CYC_2;
         end
         `XOD_OP_LDTRAPH, `XOD_OP_LDTRAPPED, `XOD_OP_STTRAPPED, `XOD_OP_STTRAPH: begin
            r.min_cyc = `XOD_CYC_12;
         end
         `XOD_OP_TRET: begin
            r.ranged = 1'b1;
            r.min_cyc = `XOD_CYC_8;
            r.max_cyc = `XOD_CYC_10;
         end
         `XOD_OP_PRODID, `XOD_OP_NOP: begin
            r.min_cyc = `XOD_CYC_1;
         end
         `XOD_OP_CLKENB, `XOD_OP_CLKDIS, `XOD_OP_LDCLK, `XOD_OP_STCLK: begin
            r.min_cyc = `XOD_CYC_2;
         end
         default: begin
            r.legal = 1'b0;
            r.min_cyc = `XOD_CYC_1;
         end
      endcase
      if (!r.ranged) begin
         r.max_cyc = r.min_cyc;
      end
      return r;
   endfunction : info

   xod_info_t cur;
   xod_state_t state_r, state_nxt;
   logic [4:0] cnt_r, cnt_nxt;
   logic [4:0] max_r, max_nxt;
   logic [15:0] op_r, op_nxt;
   logic start_nxt, start_r;
   logic illegal_nxt, illegal_r;
   logic dev_r, dev_nxt;
   logic [31:0] addr_r, addr_nxt;
   logic mem_r, mem_nxt;
   xod_target_t target;
   logic chan_area, trap_area;
   logic accept;

   assign cur = info(opcode_i);
   assign instr_ready_o = (state_r == XOD_IDLE);
   assign accept = instr_valid_i && instr_ready_o;
   assign busy_o = !instr_ready_o;

   // extra cycles available beyond the minimum; zero marks a fixed-length op
   function automatic logic [4:0] op_max_gap(input logic [15:0] op);
      xod_info_t t;
      t = info(op);
      return t.max_cyc - t.min_cyc;
   endfunction : op_max_gap

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      max_nxt = max_r;
      op_nxt = op_r;
      dev_nxt = dev_r;
      mem_nxt = mem_r;
      addr_nxt = addr_r;
      start_nxt = 1'b0;
      illegal_nxt = 1'b0;
      case (state_r)
         XOD_IDLE: begin
            if (accept) begin
               op_nxt = opcode_i;
               addr_nxt = addr_i;
               if (!cur.legal) begin
                  illegal_nxt = 1'b1;
                  dev_nxt = 1'b0;
                  mem_nxt = 1'b0;
               end else begin
                  start_nxt = 1'b1;
                  dev_nxt = cur.dev_op;
                  mem_nxt = cur.mem_op;
                  cnt_nxt = cur.min_cyc;
                  max_nxt = cur.max_cyc;
                  if (cur.min_cyc != `XOD_CYC_1) begin
                     state_nxt = XOD_BUSY;
                  end
               end
            end
         end
         XOD_BUSY: begin
            cnt_nxt = cnt_r - `XOD_CYC_1;
            if (cnt_r == `XOD_CYC_2) begin
               // ranged ops hold issue until done or their max count, fixed ops end on count
               state_nxt = (op_max_gap(op_r) != 5'h00) ? XOD_WAITDONE : XOD_IDLE;
            end
         end
         XOD_WAITDONE: begin
            cnt_nxt = cnt_r + `XOD_CYC_1;
            // cnt counts cycles past the minimum, so the gap caps the wait at max
            if (exec_done_i || cnt_r >= op_max_gap(op_r)) begin
               state_nxt = XOD_IDLE;
            end
         end
         default: begin
            state_nxt = XOD_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_r <= XOD_IDLE;
         cnt_r <= 5'h00;
         max_r <= 5'h00;
         op_r <= 16'h0000;
         start_r <= 1'b0;
         illegal_r <= 1'b0;
         dev_r <= 1'b0;
         mem_r <= 1'b0;
         addr_r <= 32'h0000_0000;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         max_r <= max_nxt;
         op_r <= op_nxt;
         start_r <= start_nxt;
         illegal_r <= illegal_nxt;
         dev_r <= dev_nxt;
         mem_r <= mem_nxt;
         addr_r <= addr_nxt;
      end
   end

   xod_addr_decode u_addr (
      .addr_i(addr_r),
      .dev_op_i(dev_r),
      .rom_programmed_i(rom_programmed_i),
      .bank_o(bank_o),
      .word_addr_o(word_addr_o),
      .byte_sel_o(byte_sel_o),
      .ext_addr_o(ext_addr_o),
      .target_o(target),
      .sram_o(),
      .chan_area_o(chan_area),
      .trap_area_o(trap_area),
      .trap_pri_o(),
      .trap_grp_o(),
      .trap_struct_o()
   );

   assign exec_start_o = start_r;
   assign exec_op_o = op_r;
   assign exec_cycles_o = max_r;
   assign illegal_o = illegal_r;
   // peripheral select only ever comes from a device op
   assign periph_sel_o = start_r && dev_r && (target == XOD_TGT_PERIPH);
   assign mem_sel_o = start_r && (dev_r || mem_r) && (target == XOD_TGT_MEM);
   assign rom_sel_o = start_r && (dev_r || mem_r) && (target == XOD_TGT_ROM);
   // ordinary access into processor-private words is flagged
   assign reserved_hit_o = start_r && mem_r && (chan_area || trap_area);
   assign boot_pc_o = boot_i ? `XOD_BOOT_ENTRY : `XOD_ROM_BASE;

   property p_fixed_len;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (accept && cur.legal && !cur.ranged && cur.min_cyc == `XOD_CYC_3) |=> !instr_ready_o ##1
         !instr_ready_o ##1 instr_ready_o;
   endproperty
   a_fixed_len: assert property (p_fixed_len) else $error("3-cycle op wrong length");
   property p_illegal;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (accept && !cur.legal) |=> illegal_o && !exec_start_o;
   endproperty
   a_illegal: assert property (p_illegal) else $error("illegal op not flagged");
   property p_one_cycle;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (accept && (opcode_i == `XOD_OP_NOP || opcode_i == `XOD_OP_LSX)) |=> instr_ready_o;
   endproperty
   a_one_cycle: assert property (p_one_cycle) else $error("1-cycle op stalled");
   property p_periph;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      periph_sel_o |-> dev_r && addr_r <= `XOD_PERIPH_HI;
   endproperty
   a_periph: assert property (p_periph) else $error("peripheral hit by non-device op");
   property p_bank;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      exec_start_o |-> bank_o == $past(addr_i[31:30]);
   endproperty
   a_bank: assert property (p_bank) else $error("bank select wrong");
   property p_wait_max;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (accept && opcode_i == `XOD_OP_WAIT) |=> !instr_ready_o [*4] ##[1:7] instr_ready_o;
   endproperty
   a_wait_max: assert property (p_wait_max) else $error("wait outside 5 to 11");
   property p_clock_ops;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (accept && opcode_i[15:8] == 8'h64 && cur.legal) |=> !instr_ready_o ##1 instr_ready_o;
   endproperty
   a_clock_ops: assert property (p_clock_ops) else $error("clock op not 2 cycles");
   // eleven busy cycles after the accept of a 12-cycle op
   sequence s_trap_busy;
      !instr_ready_o [*8] ##1 !instr_ready_o [*3];
   endsequence
   property p_trap12;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (accept && opcode_i == `XOD_OP_STTRAPH) |=> s_trap_busy ##1 instr_ready_o;
   endproperty
   a_trap12: assert property (p_trap12) else $error("trap store not 12 cycles");
   property p_done_exit;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (state_r == XOD_WAITDONE && exec_done_i) |=> instr_ready_o;
   endproperty
   a_done_exit: assert property (p_done_exit) else $error("done did not end ranged op");
endmodule : xod_decoder
`default_nettype wire

// File: testbench/xod_exec_model.sv
// execution unit stand-in that reports early completion of ranged ops
`timescale 1ns/10ps
`default_nettype none
module xod_exec_model (
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire logic exec_start_i,
   input wire logic [4:0] done_dly_i,
   output logic exec_done_o
);
   logic [4:0] cnt_r;
   // zero delay: unit never finishes early, decoder must time out at budget
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_r <= 5'h0;
         exec_done_o <= 1'b0;
      end else begin
         exec_done_o <= (cnt_r == 5'h1);
         if (exec_start_i) begin
            cnt_r <= done_dly_i;
         end else if (cnt_r != 5'h0) begin
            cnt_r <= cnt_r - 5'h1;
         end
      end
   end
endmodule : xod_exec_model
`default_nettype wire

// File: testbench/test_extended_opcode_and_address_decode.sv
// self-checking bench for the extended opcode and address decoder
`timescale 1ns/10ps
`default_nettype none
module test_extended_opcode_and_address_decode;
   import xod_pkg::*;
   localparam logic [15:0] FOP [29] = '{16'h2CF7, 16'h2CFC, 16'h2FFA, 16'h2FFB, 16'h2FF8,
      16'h2BF8, 16'h2FF9, 16'h2BF9, 16'h2FF0, 16'h2FF2, 16'h2FF4, 16'h2FF1, 16'h2FF3,
      16'h2FF5, 16'h2CFD, 16'h2CFE, 16'h2CFB, 16'h26FF, 16'h26FE, 16'h2CF6, 16'h60F7,
      16'h60F6, 16'h60F0, 16'h64FF, 16'h64FE, 16'h64FD, 16'h64FC, 16'h68FC, 16'h63F0};
   localparam int FCY [29] = '{3, 3, 3, 2, 3, 3, 1, 1, 3, 3, 3, 3, 3, 3, 5, 5, 12, 12, 12,
      12, 4, 4, 4, 2, 2, 2, 2, 1, 1};
   localparam logic [15:0] ROP [6] = '{16'h60F5, 16'h60F4, 16'h60F2, 16'h60FC, 16'h60FD,
      16'h60FB};
   localparam int RMIN [6] = '{5, 7, 3, 6, 6, 8};
   localparam int RMAX [6] = '{11, 12, 4, 31, 17, 10};
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic valid = 1'b0;
   logic [15:0] opcode = 16'h0;
   logic [31:0] addr = 32'h0;
   logic boot = 1'b0;
   logic rom_prog = 1'b1;
   logic [4:0] dly = 5'h0;
   logic done;
   logic ready, start, illegal, busy, p_sel, m_sel, r_sel, resv;
   logic [15:0] x_op;
   logic [4:0] x_cyc;
   logic [1:0] bank, bsel;
   logic [29:0] waddr;
   logic [19:0] eaddr;
   logic [31:0] boot_pc;
   int n_fail = 0;
   int samples_checked = 0;
   int cyc = 0;
   always #2 clk = ~clk;
   xod_decoder dut_u (.clk_sys_i(clk), .arst_n_i(arst_n), .instr_valid_i(valid),
      .opcode_i(opcode), .addr_i(addr), .exec_done_i(done), .boot_i(boot),
      .rom_programmed_i(rom_prog), .instr_ready_o(ready), .exec_start_o(start),
      .exec_op_o(x_op), .exec_cycles_o(x_cyc), .illegal_o(illegal), .busy_o(busy),
      .periph_sel_o(p_sel), .mem_sel_o(m_sel), .rom_sel_o(r_sel), .bank_o(bank),
      .word_addr_o(waddr), .byte_sel_o(bsel), .ext_addr_o(eaddr), .reserved_hit_o(resv),
      .boot_pc_o(boot_pc));
   xod_exec_model exec_u (.clk_sys_i(clk), .arst_n_i(arst_n), .exec_start_i(start),
      .done_dly_i(dly), .exec_done_o(done));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : chk
   // waits for idle, offers one op, returns in the cycle after the accept edge
   task automatic issue(input logic [15:0] op, input logic [31:0] a);
      int k;
      k = 0;
      while (ready !== 1'b1 && k < 64) begin
         @(negedge clk);
         k++;
      end
      @(posedge clk);
      valid <= 1'b1;
      opcode <= op;
      addr <= a;
      @(posedge clk);
      valid <= 1'b0;
      @(negedge clk);
   endtask : issue
   task automatic busy_len(output int n);
      n = 0;
      while (busy !== 1'b0 && n < 40) begin
         @(negedge clk);
         n++;
      end
   endtask : busy_len
   task automatic t_fixed();
      int n;
      for (int i = 0; i < 29; i++) begin
         issue(FOP[i], 32'h8000_0400);
         chk(start, 1'b1, "start");
         chk(x_op, FOP[i], "op");
         chk(x_cyc, FCY[i], "budget");
         busy_len(n);
         chk(n, FCY[i] - 1, "busy");
      end
      $display("fixed budgets done");
   endtask : t_fixed
   task automatic t_ranged();
      int n;
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         dly <= 5'h0;
         issue(ROP[i], 32'h8000_0400);
         chk(x_cyc, RMAX[i], "max");
         busy_len(n);
         chk(n, RMAX[i] - 1, "no done");
         @(posedge clk);
         dly <= 5'(RMIN[i] + 1);
         issue(ROP[i], 32'h8000_0400);
         busy_len(n);
         chk(32'(n >= RMIN[i] - 1 && n <= RMAX[i] - 1), 32'h1, "early");
         // model raises done in op cycle dly+3; the budget caps the wait
         chk(n, (RMIN[i] + 3 < RMAX[i] - 1) ? RMIN[i] + 3 : RMAX[i] - 1, "done exit");
      end
      @(posedge clk);
      dly <= 5'h0;
      $display("ranged budgets done");
   endtask : t_ranged
   task automatic t_illegal();
      logic [15:0] bad [4];
      int n;
      bad = '{16'h2FF7, 16'h2CFF, 16'h6FFF, 16'h0000};
      for (int i = 0; i < 4; i++) begin
         issue(bad[i], 32'h8000_0400);
         chk(illegal, 1'b1, "illegal");
         chk(start, 1'b0, "no start");
         busy_len(n);
         chk(n, 32'h0, "illegal busy");
      end
      $display("illegal codes done");
   endtask : t_illegal
   task automatic ac(input logic [15:0] op, input logic [31:0] a, input logic [3:0] prmh);
      int n;
      issue(op, a);
      chk(p_sel, prmh[3], "periph");
      chk(m_sel, prmh[2], "mem");
      chk(r_sel, prmh[1], "rom");
      chk(resv, prmh[0], "resv");
      chk(bank, a[31:30], "bank");
      chk(waddr, a[31:2], "word");
      chk(bsel, a[1:0], "byte");
      chk(eaddr, a[19:0], "ext");
      busy_len(n);
   endtask : ac
   task automatic t_addr();
      ac(16'h2FF5, 32'h2000_1004, 4'b1000);
      ac(16'h2FF0, 32'h3FFF_FFFC, 4'b1000);
      ac(16'h2FF0, 32'h4000_0001, 4'b0100);
      ac(16'h2FF0, 32'h8000_0400, 4'b0100);
      ac(16'h2FF9, 32'h2000_1006, 4'b0100);
      ac(16'h2FF9, 32'h8000_0010, 4'b0101);
      ac(16'h2FF1, 32'h8000_0010, 4'b0100);
      ac(16'h2FF9, 32'h8000_0040, 4'b0101);
      ac(16'h2FF9, 32'h8000_013C, 4'b0101);
      ac(16'h2FF9, 32'h8000_0140, 4'b0100);
      ac(16'h2FF9, 32'h8100_0000, 4'b0100);
      ac(16'h2FF9, 32'hC000_0003, 4'b0100);
      ac(16'h2BF9, 32'h7FFE_0010, 4'b0010);
      @(posedge clk);
      rom_prog <= 1'b0;
      ac(16'h2BF9, 32'h7FFE_0010, 4'b0100);
      @(posedge clk);
      rom_prog <= 1'b1;
      $display("address decode done");
   endtask : t_addr
   task automatic t_boot_reset();
      @(posedge clk);
      boot <= 1'b1;
      @(negedge clk);
      chk(boot_pc, 32'h7FFF_FFFE, "boot");
      @(posedge clk);
      boot <= 1'b0;
      @(negedge clk);
      chk(boot_pc, 32'h7FFE_0000, "rom base");
      issue(16'h26FF, 32'h8000_0400);
      @(posedge clk);
      arst_n <= 1'b0;
      @(negedge clk);
      chk(ready, 1'b1, "rst ready");
      chk(start, 1'b0, "rst start");
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      issue(16'h63F0, 32'h8000_0400);
      chk(start, 1'b1, "after rst");
      $display("boot and reset done");
   endtask : t_boot_reset
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_fail++;
         end_sim();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      @(negedge clk);
      chk(ready, 1'b1, "idle ready");
      chk(illegal, 1'b0, "idle illegal");
      t_fixed();
      t_ranged();
      t_illegal();
      t_addr();
      t_boot_reset();
      end_sim();
   end
endmodule : test_extended_opcode_and_address_decode
`default_nettype wire
